// file: inc/tgsl_pkg.sv
// constants and carrier types for the triangle geometry serial loader
package tgsl_pkg;

   // word slots
   localparam logic [2:0] SLOT_FIRST_X  = 3'h0;
   localparam logic [2:0] SLOT_FIRST_Y  = 3'h1;
   localparam logic [2:0] SLOT_SECOND_X = 3'h2;
   localparam logic [2:0] SLOT_SECOND_Y = 3'h3;
   localparam logic [2:0] SLOT_THIRD_X  = 3'h4;
   localparam logic [2:0] SLOT_THIRD_Y  = 3'h5;
   localparam logic [2:0] SLOT_FILL     = 3'h6;
   localparam logic [2:0] SLOT_BACK     = 3'h7;
   localparam int         SLOT_COUNT    = 8;
   localparam int         WORD_BITS     = 8;
   localparam int         COORD_BITS    = 6;
   localparam int         PIXELS_PER_STEP = 8;
   localparam logic [2:0] LAST_BIT      = 3'h7;

   // reset contents: red fill on white, coordinates at origin
   localparam logic [7:0] RESET_COORD   = 8'h00;
   localparam logic [7:0] RESET_FILL    = 8'h03;
   localparam logic [7:0] RESET_BACK    = 8'h3f;

   // two-way port lanes
   localparam int         UIO_WIDTH     = 8;
   localparam int         PIN_CS        = 0;
   localparam int         PIN_MOSI      = 1;
   localparam int         PIN_SCK       = 3;
   localparam int         PIN_VSYNC     = 4;
   localparam int         PIN_HSYNC     = 5;
   localparam logic [7:0] UIO_OE_MASK   = 8'h30;

   // timing
   localparam int         CLK_PERIOD_PS     = 8000;
   localparam int         SCK_MAX_FREQ_KHZ  = 12000;
   localparam int         SCK_MIN_PERIOD_PS = 1000000000 / SCK_MAX_FREQ_KHZ;
   localparam int         SCK_MIN_PERIOD_CYC =
      (SCK_MIN_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int         FIFO_DEPTH        = 16;

   typedef struct packed {
      logic [1:0] blue;
      logic [1:0] green;
      logic [1:0] red;
   } tgsl_colour_t;

   typedef struct packed {
      logic [COORD_BITS-1:0] y;
      logic [COORD_BITS-1:0] x;
   } tgsl_vertex_t;

   typedef struct packed {
      tgsl_colour_t background;
      tgsl_colour_t fill;
      tgsl_vertex_t third;
      tgsl_vertex_t second;
      tgsl_vertex_t first;
   } tgsl_geom_t;

   typedef struct packed {
      logic [2:0]           slot;
      logic [WORD_BITS-1:0] data;
   } tgsl_word_t;

endpackage : tgsl_pkg

// file: rtl/tgsl_serial_loader.sv
// serial geometry loader with its word fifo
// Overview of operation
// - slots 0..5 hold X then Y of first, second, third vertex
// - slot 6 is fill colour, 2-bit red in low bits, then green, blue
// - slot 7 is background colour, packed like the fill colour
// - chip select high then low restarts bit and slot counters, data kept
// - each received word lands in its slot when drained from the word fifo while slotHold is low, no shadow copy
// - vsync and hsync copies driven out on the two-way port
// - one bit taken per rising serial clock while chip select is low
// - words are eight bits, most significant bit first, top two bits ignored
// - after the eighth word the slot counter wraps to slot 0
// - coordinates carry six significant bits, one step is eight pixels
`timescale 1ns/100ps
`default_nettype none

module tgsl_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // clock and reset
   input  wire logic             ref_clk,
   input  wire logic             resetn,
   // fill side
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   // drain side
   output logic                  outValid,
   input  wire logic             outReady,
   output logic [WIDTH-1:0]      outData
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW-1:0]    wrPtr_ff, nxt_wrPtr;
   logic [AW-1:0]    rdPtr_ff, nxt_rdPtr;
   logic [AW:0]      count_ff, nxt_count;
   logic             push, pop;

   assign inReady  = (count_ff != (AW+1)'(DEPTH));
   assign outValid = (count_ff != '0);
   assign outData  = mem_ff[rdPtr_ff];
   assign push     = inValid & inReady;
   assign pop      = outValid & outReady;

   always_comb begin
      nxt_wrPtr = push ? wrPtr_ff + 1'b1 : wrPtr_ff;
      nxt_rdPtr = pop ? rdPtr_ff + 1'b1 : rdPtr_ff;
      nxt_count = count_ff;
      if (push && !pop) begin
         nxt_count = count_ff + 1'b1;
      end else if (pop && !push) begin
         nxt_count = count_ff - 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         wrPtr_ff <= '0;
         rdPtr_ff <= '0;
         count_ff <= '0;
      end else begin
         wrPtr_ff <= nxt_wrPtr;
         rdPtr_ff <= nxt_rdPtr;
         count_ff <= nxt_count;
      end
   end

   // payload storage needs no reset, only the pointers and the count do
   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem_ff[wrPtr_ff] <= inData;
      end
   end

endmodule : tgsl_fifo

module tgsl_serial_loader (
   // clock and reset
   input  wire logic                       ref_clk,
   input  wire logic                       resetn,
   // two-way port: chip select, data, serial clock in; syncs out
   input  wire logic [tgsl_pkg::UIO_WIDTH-1:0] uioIn,
   output logic [tgsl_pkg::UIO_WIDTH-1:0]      uioOut,
   output logic [tgsl_pkg::UIO_WIDTH-1:0]      uioOe,
   // video timing from the sync generator
   input  wire logic                       vsyncIn,
   input  wire logic                       hsyncIn,
   // rasterizer side
   input  wire logic                       slotHold,
   output var tgsl_pkg::tgsl_geom_t        geometry,
   output logic                            wordDropped
);
   import tgsl_pkg::*;
   function automatic logic [COORD_BITS-1:0] coordOf(input logic [WORD_BITS-1:0] w);
      coordOf = w[COORD_BITS-1:0];
   endfunction : coordOf
   function automatic tgsl_colour_t colourOf(input logic [WORD_BITS-1:0] w);
      colourOf = tgsl_colour_t'(w[$bits(tgsl_colour_t)-1:0]);
   endfunction : colourOf
   // synchronisers and edge detection
   logic [2:0] syncA_ff, syncB_ff, nxt_syncA, nxt_syncB;
   logic       sckPrev_ff, nxt_sckPrev;
   logic       csHigh, mosiBit, sckRise;
   always_comb begin
      nxt_syncA   = {uioIn[PIN_SCK], uioIn[PIN_MOSI], uioIn[PIN_CS]};
      nxt_syncB   = syncA_ff;
      nxt_sckPrev = syncB_ff[2];
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         syncA_ff   <= 3'h1;
         syncB_ff   <= 3'h1;
         sckPrev_ff <= 1'b0;
      end else begin
         syncA_ff   <= nxt_syncA;
         syncB_ff   <= nxt_syncB;
         sckPrev_ff <= nxt_sckPrev;
      end
   end

   assign csHigh  = syncB_ff[0];
   assign mosiBit = syncB_ff[1];
   assign sckRise = syncB_ff[2] & ~sckPrev_ff;
   // shifter and counters
   logic [WORD_BITS-1:0] shift_ff, nxt_shift;
   logic [2:0]           bitCnt_ff, nxt_bitCnt;
   logic [2:0]           slotIdx_ff, nxt_slotIdx;
   logic                 pushValid_ff, nxt_pushValid;
   tgsl_word_t           pushWord_ff, nxt_pushWord;
   logic                 dropped_ff, nxt_dropped;
   logic                 fifoInReady;

   always_comb begin
      nxt_shift     = shift_ff;
      nxt_bitCnt    = bitCnt_ff;
      nxt_slotIdx   = slotIdx_ff;
      nxt_pushValid = pushValid_ff & ~fifoInReady;
      nxt_pushWord  = pushWord_ff;
      // a word that meets a full fifo waits and is flagged; the next word would overwrite it
      nxt_dropped   = dropped_ff | (pushValid_ff & ~fifoInReady);
      if (csHigh) begin
         nxt_bitCnt  = '0;
         nxt_slotIdx = '0;
      end else if (sckRise) begin
         nxt_shift  = {shift_ff[WORD_BITS-2:0], mosiBit};
         nxt_bitCnt = bitCnt_ff + 1'b1;
         if (bitCnt_ff == LAST_BIT) begin
            nxt_pushValid     = 1'b1;
            nxt_pushWord.slot = slotIdx_ff;
            nxt_pushWord.data = {shift_ff[WORD_BITS-2:0], mosiBit};
            nxt_slotIdx       = slotIdx_ff + 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         shift_ff     <= '0;
         bitCnt_ff    <= '0;
         slotIdx_ff   <= '0;
         pushValid_ff <= 1'b0;
         pushWord_ff  <= '0;
         dropped_ff   <= 1'b0;
      end else begin
         shift_ff     <= nxt_shift;
         bitCnt_ff    <= nxt_bitCnt;
         slotIdx_ff   <= nxt_slotIdx;
         pushValid_ff <= nxt_pushValid;
         pushWord_ff  <= nxt_pushWord;
         dropped_ff   <= nxt_dropped;
      end
   end

   // word fifo between the serial side and the slots
   logic       drainValid;
   tgsl_word_t drainWord;
   logic       drainTake;

   tgsl_fifo #(
      .WIDTH ($bits(tgsl_word_t)),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .ref_clk  (ref_clk),
      .resetn   (resetn),
      .inValid  (pushValid_ff),
      .inReady  (fifoInReady),
      .inData   (pushWord_ff),
      .outValid (drainValid),
      .outReady (~slotHold),
      .outData  (drainWord)
   );

   assign drainTake = drainValid & ~slotHold;
   // slot storage, written straight through with no shadow copy
   logic [WORD_BITS-1:0] slotMem_ff [SLOT_COUNT];
   logic [WORD_BITS-1:0] nxt_slotMem [SLOT_COUNT];
   always_comb begin
      nxt_slotMem = slotMem_ff;
      if (drainTake) begin
         nxt_slotMem[drainWord.slot] = drainWord.data;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         for (int i = 0; i < SLOT_COUNT; i++) begin
            slotMem_ff[i] <= RESET_COORD;
         end
         slotMem_ff[SLOT_FILL] <= RESET_FILL;
         slotMem_ff[SLOT_BACK] <= RESET_BACK;
      end else begin
         slotMem_ff <= nxt_slotMem;
      end
   end

   // the rasterizer scales each coordinate step by PIXELS_PER_STEP itself
   assign geometry.first.x    = coordOf(slotMem_ff[SLOT_FIRST_X]);
   assign geometry.first.y    = coordOf(slotMem_ff[SLOT_FIRST_Y]);
   assign geometry.second.x   = coordOf(slotMem_ff[SLOT_SECOND_X]);
   assign geometry.second.y   = coordOf(slotMem_ff[SLOT_SECOND_Y]);
   assign geometry.third.x    = coordOf(slotMem_ff[SLOT_THIRD_X]);
   assign geometry.third.y    = coordOf(slotMem_ff[SLOT_THIRD_Y]);
   assign geometry.fill       = colourOf(slotMem_ff[SLOT_FILL]);
   assign geometry.background = colourOf(slotMem_ff[SLOT_BACK]);
   assign wordDropped         = dropped_ff;

   // sync copies for host pacing
   logic [UIO_WIDTH-1:0] uioOut_ff, nxt_uioOut;
   logic [UIO_WIDTH-1:0] uioOe_ff, nxt_uioOe;
   always_comb begin
      nxt_uioOut            = '0;
      nxt_uioOut[PIN_VSYNC] = vsyncIn;
      nxt_uioOut[PIN_HSYNC] = hsyncIn;
      nxt_uioOe             = UIO_OE_MASK;
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         uioOut_ff <= '0;
         uioOe_ff  <= '0;
      end else begin
         uioOut_ff <= nxt_uioOut;
         uioOe_ff  <= nxt_uioOe;
      end
   end

   assign uioOut = uioOut_ff;
   assign uioOe  = uioOe_ff;
   // checks
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!resetn);

   sequence s_drain;
      drainTake;
   endsequence
   property p_cs_restart;
      csHigh |=> (bitCnt_ff == '0) && (slotIdx_ff == '0);
   endproperty
   a_cs_restart: assert property (p_cs_restart)
      else $error("counters not restarted under chip select high");

   property p_cs_keeps_data;
      (csHigh && !drainValid) |=> $stable(slotMem_ff[SLOT_FIRST_X]);
   endproperty
   a_cs_keeps_data: assert property (p_cs_keeps_data)
      else $error("slot contents changed without a drained word");

   property p_bit_step;
      (sckRise && !csHigh) |=> bitCnt_ff == $past(bitCnt_ff) + 3'h1;
   endproperty
   a_bit_step: assert property (p_bit_step)
      else $error("bit counter did not advance on serial clock rise");

   property p_msb_last_bit;
      (sckRise && !csHigh && bitCnt_ff == LAST_BIT) |=>
         pushValid_ff && pushWord_ff.data[0] == $past(mosiBit)
         && pushWord_ff.data[WORD_BITS-1] == $past(shift_ff[WORD_BITS-2]);
   endproperty
   a_msb_last_bit: assert property (p_msb_last_bit)
      else $error("word not assembled most significant bit first");

   property p_slot_wrap;
      (sckRise && !csHigh && bitCnt_ff == LAST_BIT && slotIdx_ff == SLOT_BACK)
         |=> slotIdx_ff == SLOT_FIRST_X;
   endproperty
   a_slot_wrap: assert property (p_slot_wrap)
      else $error("slot counter did not wrap after the eighth word");

   property p_immediate_write;
      s_drain |=> slotMem_ff[$past(drainWord.slot)] == $past(drainWord.data);
   endproperty
   a_immediate_write: assert property (p_immediate_write)
      else $error("drained word not stored in its slot next cycle");

   property p_fill_red_low;
      (s_drain and drainWord.slot == SLOT_FILL) |=>
         geometry.fill.red == $past(drainWord.data[1:0]);
   endproperty
   a_fill_red_low: assert property (p_fill_red_low)
      else $error("fill red channel not in low bits");

   property p_back_blue;
      (s_drain and drainWord.slot == SLOT_BACK) |=>
         geometry.background.blue == $past(drainWord.data[5:4]);
   endproperty
   a_back_blue: assert property (p_back_blue)
      else $error("background blue channel misplaced");

   property p_vertex_map;
      (s_drain and drainWord.slot == SLOT_SECOND_Y) |=>
         geometry.second.y == $past(drainWord.data[COORD_BITS-1:0]);
   endproperty
   a_vertex_map: assert property (p_vertex_map)
      else $error("second vertex Y not taken from its slot");

   property p_sync_copy;
      resetn |=> (uioOut_ff[PIN_VSYNC] == $past(vsyncIn))
         && (uioOut_ff[PIN_HSYNC] == $past(hsyncIn)) && (uioOe_ff == UIO_OE_MASK);
   endproperty
   a_sync_copy: assert property (p_sync_copy)
      else $error("sync copies not driven on the two-way port");

   property p_sck_sync_delay;
      ($rose(uioIn[PIN_SCK]) ##1 uioIn[PIN_SCK][*2]) |-> sckRise;
   endproperty
   a_sck_sync_delay: assert property (p_sck_sync_delay)
      else $error("serial clock edge not seen two cycles after the pin");

endmodule : tgsl_serial_loader

`default_nettype wire

// file: tb/tgsl_host_model.sv
// host model: one-way serial master that loads geometry words
`timescale 1ns/100ps
`default_nettype none

module tgsl_host_model #(
   parameter real HALF = 62.5,
   parameter real SKEW = 0.3
) (
   // serial lines towards the loader
   output logic csN,
   output logic mosi,
   output logic sck
);

   initial begin
      csN  = 1'b1;
      mosi = 1'b0;
      sck  = 1'b0;
   end

   // clock stands low between frames; a frame starts only after vsync or hsync, see caller
   // the skew keeps every later pin change off the loader's sampling edge
   task automatic frameStart();
      #(SKEW);
      csN = 1'b0;
      #(HALF);
   endtask : frameStart

   // data changes only while the clock is low, half a period before each rise
   task automatic sendBits(input logic [7:0] data, input int n);
      for (int i = 7; i > 7 - n; i--) begin
         mosi = data[i];
         #(HALF);
         sck = 1'b1;
         #(HALF);
         sck = 1'b0;
      end
   endtask : sendBits

   // a released data line shows the inverse of its last bit, never a stale copy
   task automatic frameEnd();
      #(HALF);
      csN  = 1'b1;
      mosi = ~mosi;
   endtask : frameEnd

endmodule : tgsl_host_model
`default_nettype wire

// file: tb/tb.sv
// self-checking bench for the serial geometry loader
`timescale 1ns/100ps
`default_nettype none

module tb;
   import tgsl_pkg::*;

   localparam int LIMIT = 30000;

   logic           ref_clk;
   logic           resetn;
   logic           vsyncIn;
   logic           hsyncIn;
   logic           slotHold;
   logic           csN;
   logic           mosi;
   logic           sck;
   logic [7:0]     uioIn;
   logic [7:0]     uioOut;
   logic [7:0]     uioOe;
   tgsl_geom_t     geometry;
   logic           wordDropped;
   int             miscompares = 0;
   int             checked = 0;
   int             cycles = 0;

   // pin level of the outputs only where the loader drives them
   assign uioIn = {uioOe[7:4] & uioOut[7:4], sck, 1'b0, mosi, csN};

   tgsl_serial_loader tgsl_serial_loader_inst (
      .ref_clk     (ref_clk),
      .resetn      (resetn),
      .uioIn       (uioIn),
      .uioOut      (uioOut),
      .uioOe       (uioOe),
      .vsyncIn     (vsyncIn),
      .hsyncIn     (hsyncIn),
      .slotHold    (slotHold),
      .geometry    (geometry),
      .wordDropped (wordDropped)
   );

   tgsl_host_model tgsl_host_model_inst (
      .csN  (csN),
      .mosi (mosi),
      .sck  (sck)
   );

   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   task automatic summarize();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : summarize

   // a hang counts as a mismatch and still reaches the report
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         miscompares++;
         summarize();
      end
   end

   task automatic check(input logic [35:0] seen, input logic [35:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   function automatic logic [5:0] slotOf(input tgsl_geom_t g, input int i);
      case (i)
         0: slotOf = g.first.x;
         1: slotOf = g.first.y;
         2: slotOf = g.second.x;
         3: slotOf = g.second.y;
         4: slotOf = g.third.x;
         5: slotOf = g.third.y;
         6: slotOf = g.fill;
         default: slotOf = g.background;
      endcase
   endfunction : slotOf

   // pulse vsync (hsync when there is headroom), open a frame once the copy is seen
   task automatic startFrame(input bit fromHsync = 1'b0);
      @(posedge ref_clk) {hsyncIn, vsyncIn} <= {fromHsync, ~fromHsync};
      repeat (2) @(posedge ref_clk);
      check(uioOut[PIN_HSYNC:PIN_VSYNC], {fromHsync, ~fromHsync});
      {hsyncIn, vsyncIn} <= 2'b00;
      tgsl_host_model_inst.frameStart();
   endtask : startFrame

   task automatic testReset();
      check(uioOe, UIO_OE_MASK);
      for (int i = 0; i < 6; i++)
         check(slotOf(geometry, i), RESET_COORD[5:0]);
      check(geometry.fill, RESET_FILL[5:0]);
      check(geometry.background, RESET_BACK[5:0]);
      check(wordDropped, 1'b0);
   endtask : testReset

   task automatic testSyncs();
      for (int i = 0; i < 4; i++) begin
         @(posedge ref_clk) {hsyncIn, vsyncIn} <= i[1:0];
         @(posedge ref_clk) #1;
         check(uioOut, {2'h0, i[1:0], 4'h0});
      end
      @(posedge ref_clk) {hsyncIn, vsyncIn} <= 2'b00;
   endtask : testSyncs

   // upper bits set on purpose: only six bits of each coordinate count
   task automatic testFrame();
      logic [7:0] w [8] = '{8'hc5, 8'h9a, 8'h31, 8'h7e, 8'h4c, 8'h23, 8'hdb, 8'h36};
      startFrame();
      for (int i = 0; i < 8; i++) begin
         tgsl_host_model_inst.sendBits(w[i], 8);
         check(slotOf(geometry, i), w[i][5:0]);
      end
      tgsl_host_model_inst.frameEnd();
      check(geometry.fill.red, 2'b11);
      check(geometry.fill.blue, 2'b01);
      check(geometry.background.red, 2'b10);
      check(geometry.background.blue, 2'b11);
   endtask : testFrame

   task automatic testWrap();
      startFrame();
      for (int i = 0; i < 9; i++)
         tgsl_host_model_inst.sendBits(8'h10 + i[7:0], 8);
      tgsl_host_model_inst.frameEnd();
      check(slotOf(geometry, 0), 6'h18);
      check(slotOf(geometry, 1), 6'h11);
   endtask : testWrap

   // a partial word is thrown away and the next frame starts at slot 0
   task automatic testRestart();
      startFrame();
      tgsl_host_model_inst.sendBits(8'hff, 4);
      tgsl_host_model_inst.frameEnd();
      check(slotOf(geometry, 0), 6'h18);
      startFrame(1'b1);
      tgsl_host_model_inst.sendBits(8'h2a, 8);
      tgsl_host_model_inst.frameEnd();
      check(slotOf(geometry, 0), 6'h2a);
      check(slotOf(geometry, 1), 6'h11);
   endtask : testRestart

   // seventeen words against a stalled drain: sixteen queue, the last waits and is flagged
   task automatic testFifo();
      check(wordDropped, 1'b0);
      @(posedge ref_clk) slotHold <= 1'b1;
      startFrame();
      for (int i = 0; i < 17; i++)
         tgsl_host_model_inst.sendBits(8'hc0 + i[7:0], 8);
      tgsl_host_model_inst.frameEnd();
      check(slotOf(geometry, 0), 6'h2a);
      check(wordDropped, 1'b1);
      @(posedge ref_clk) slotHold <= 1'b0;
      repeat (24) @(posedge ref_clk);
      check(slotOf(geometry, 0), 6'h10);
      for (int i = 1; i < 8; i++)
         check(slotOf(geometry, i), 6'(i + 8));
   endtask : testFifo

   initial begin
      resetn   = 1'b0;
      vsyncIn  = 1'b0;
      hsyncIn  = 1'b0;
      slotHold = 1'b0;
      repeat (12) @(posedge ref_clk);
      #1;
      check(uioOe, 8'h00);
      @(posedge ref_clk) resetn <= 1'b1;
      repeat (3) @(posedge ref_clk);
      #1;
      testReset();
      testSyncs();
      testFrame();
      testWrap();
      testRestart();
      testFifo();
      summarize();
   end

endmodule : tb
`default_nettype wire
